// ==== rtl/afc_format_ctrl.sv ====
// Overview of operation
// - opcode 50h formats exactly one logical track, old data lost
// - every good sector of the track is written with zeros
// - no read-back check of zeroed sectors
// - one-sector format table is accepted, its content ignored
// - track layout always ascending 1:1, regardless of table
// - in lba mode current lba reported back in the same registers
// - lba beyond range aborts the track format
// - lba mode selects the logical track holding the given lba
// - opcode f7h merges reassignments into defects, then writes all good sectors
// - old records erased, new records committed at completion
// - unit format covers lba 0 to native top, ignoring limits
// - unit format without preceding erase-prepare is aborted
// - unit format has no data phase, drq never set
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module afc_format_ctrl (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // media zero-write port
    output logic             zero_wr_req_o,
    output logic      [27:0] zero_wr_lba_o,
    input  wire logic        zero_wr_ack_i,
    input  wire logic        defect_hit_i,
    // defect records
    output logic             merge_req_o,
    input  wire logic        merge_ack_i,
    output logic             records_commit_o,
    // erase-prepare completion
    input  wire logic        erase_prepared_i
);

    afc_pkg::afc_state_t state;
    logic [7:0]  feature;
    logic [7:0]  sector_count;
    logic [7:0]  sector_number;
    logic [7:0]  cylinder_low;
    logic [7:0]  cylinder_high;
    logic [7:0]  device_head;
    logic [27:0] native_top_address;
    logic [7:0]  error_flags;
    logic [7:0]  command_status;
    logic        prepared;
    logic        unit_mode;
    logic [7:0]  table_count;
    logic [27:0] cur_lba;
    logic [27:0] last_lba;
    logic        abort_flag;
    logic        lba_mode;
    logic [27:0] first_lba;
    logic [27:0] calc_last_lba;
    logic        in_range;
    logic        wb_access;
    logic        wb_write;
    logic        busy;
    logic        cmd_fire;
    logic        data_fire;
    logic        sector_step;

    // ****************************************
    // bus decode
    // ****************************************
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] ofs);
        reg_hit = (adr == ofs);
    endfunction
    assign wb_access   = cyc_i && stb_i && !ack_o;
    assign wb_write    = wb_access && we_i && sel_i[0];
    assign busy        = (state != afc_pkg::AFC_IDLE);
    assign cmd_fire    = wb_write && !busy
                         && reg_hit(adr_i, afc_pkg::AFC_OFS_COMMAND);
    assign data_fire   = wb_write && (state == afc_pkg::AFC_TABLE)
                         && reg_hit(adr_i, afc_pkg::AFC_OFS_DATA);
    assign lba_mode    = device_head[afc_pkg::AFC_DH_LBA_BIT];
    // a defective sector is skipped, a good one waits for its write
    assign sector_step = (state == afc_pkg::AFC_ISSUE)
                         && (defect_hit_i || zero_wr_ack_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_access;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (wb_access && !we_i) begin
            case (adr_i)
                afc_pkg::AFC_OFS_FEATURE:  dat_o <= {24'h0, error_flags};
                afc_pkg::AFC_OFS_SECT_CNT: dat_o <= {24'h0, sector_count};
                afc_pkg::AFC_OFS_SECT_NUM: dat_o <= {24'h0, sector_number};
                afc_pkg::AFC_OFS_CYL_LOW:  dat_o <= {24'h0, cylinder_low};
                afc_pkg::AFC_OFS_CYL_HIGH: dat_o <= {24'h0, cylinder_high};
                afc_pkg::AFC_OFS_DEV_HEAD: dat_o <= {24'h0, device_head};
                afc_pkg::AFC_OFS_COMMAND:  dat_o <= {24'h0, command_status};
                afc_pkg::AFC_OFS_NATIVE:   dat_o <= {4'h0, native_top_address};
                default:                   dat_o <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // task file
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feature       <= 8'h0;
            sector_count  <= 8'h0;
            sector_number <= 8'h0;
            cylinder_low  <= 8'h0;
            cylinder_high <= 8'h0;
            device_head   <= afc_pkg::AFC_RST_DEV_HEAD;
        end else if (state == afc_pkg::AFC_DONE && !unit_mode && lba_mode
                     && !abort_flag) begin
            // report the last lba handled
            sector_number <= cur_lba[7:0];
            cylinder_low  <= cur_lba[15:8];
            cylinder_high <= cur_lba[23:16];
            device_head   <= {device_head[7:4], cur_lba[27:24]};
        end else if (wb_write && !busy) begin
            case (adr_i)
                afc_pkg::AFC_OFS_FEATURE:  feature       <= dat_i[7:0];
                afc_pkg::AFC_OFS_SECT_CNT: sector_count  <= dat_i[7:0];
                afc_pkg::AFC_OFS_SECT_NUM: sector_number <= dat_i[7:0];
                afc_pkg::AFC_OFS_CYL_LOW:  cylinder_low  <= dat_i[7:0];
                afc_pkg::AFC_OFS_CYL_HIGH: cylinder_high <= dat_i[7:0];
                afc_pkg::AFC_OFS_DEV_HEAD: device_head   <= dat_i[7:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            native_top_address <= afc_pkg::AFC_RST_NATIVE;
        end else if (wb_write && !busy && sel_i == 4'hf
                     && reg_hit(adr_i, afc_pkg::AFC_OFS_NATIVE)) begin
            native_top_address <= dat_i[27:0];
        end
    end

    afc_track_calc u_track (
        .lba_mode_i      (lba_mode),
        .sector_number_i (sector_number),
        .cylinder_i      ({cylinder_high, cylinder_low}),
        .head_i          (device_head[3:0]),
        .native_top_i    (native_top_address),
        .target_lba_o    (),
        .first_lba_o     (first_lba),
        .last_lba_o      (calc_last_lba),
        .in_range_o      (in_range)
    );

    // ****************************************
    // erase-prepare tracking
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prepared <= 1'b0;
        end else if (erase_prepared_i) begin
            prepared <= 1'b1;
        end else if (cmd_fire) begin
            // any command consumes the preparation
            prepared <= 1'b0;
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state       <= afc_pkg::AFC_IDLE;
            unit_mode   <= 1'b0;
            abort_flag  <= 1'b0;
            table_count <= 8'h0;
            cur_lba     <= 28'h0;
            last_lba    <= 28'h0;
        end else begin
            case (state)
                afc_pkg::AFC_IDLE: begin
                    if (cmd_fire) begin
                        abort_flag  <= 1'b0;
                        table_count <= 8'h0;
                        case (dat_i[7:0])
                            afc_pkg::AFC_OP_TRACK: begin
                                unit_mode <= 1'b0;
                                if (!in_range) begin
                                    abort_flag <= 1'b1;
                                    state      <= afc_pkg::AFC_DONE;
                                end else begin
                                    state <= afc_pkg::AFC_TABLE;
                                end
                            end
                            afc_pkg::AFC_OP_UNIT: begin
                                unit_mode <= 1'b1;
                                if (!prepared) begin
                                    abort_flag <= 1'b1;
                                    state      <= afc_pkg::AFC_DONE;
                                end else begin
                                    state <= afc_pkg::AFC_MERGE;
                                end
                            end
                            default: begin
                                unit_mode  <= 1'b0;
                                abort_flag <= 1'b1;
                                state      <= afc_pkg::AFC_DONE;
                            end
                        endcase
                    end
                end
                afc_pkg::AFC_TABLE: begin
                    // table words are counted, their values dropped
                    if (data_fire) begin
                        table_count <= table_count + 8'h1;
                        if (table_count == afc_pkg::AFC_TABLE_WORDS_M1) begin
                            cur_lba  <= first_lba;
                            last_lba <= calc_last_lba;
                            state    <= afc_pkg::AFC_ISSUE;
                        end
                    end
                end
                afc_pkg::AFC_MERGE: begin
                    if (merge_ack_i) begin
                        cur_lba  <= 28'h0;
                        last_lba <= native_top_address;
                        state    <= afc_pkg::AFC_ISSUE;
                    end
                end
                afc_pkg::AFC_ISSUE: begin
                    // ascending order, no verify pass afterwards
                    if (sector_step) begin
                        if (cur_lba == last_lba) begin
                            state <= afc_pkg::AFC_DONE;
                        end else begin
                            cur_lba <= cur_lba + 28'h1;
                        end
                    end
                end
                afc_pkg::AFC_DONE: begin
                    state <= afc_pkg::AFC_IDLE;
                end
                default: begin
                    state <= afc_pkg::AFC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // media and defect handshakes
    // ****************************************
    assign zero_wr_req_o = (state == afc_pkg::AFC_ISSUE)
                           && !defect_hit_i;
    assign zero_wr_lba_o = cur_lba;
    assign merge_req_o   = (state == afc_pkg::AFC_MERGE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            records_commit_o <= 1'b0;
        end else begin
            records_commit_o <= (state == afc_pkg::AFC_DONE)
                                && unit_mode && !abort_flag;
        end
    end

    // ****************************************
    // error and status
    // ****************************************
    always_comb begin
        error_flags = 8'h0;
        error_flags[afc_pkg::AFC_ER_ABT] = abort_flag;
        error_flags[afc_pkg::AFC_ER_IDN] = 1'b0;
    end

    always_comb begin
        command_status = 8'h0;
        command_status[afc_pkg::AFC_ST_BSY] = busy;
        command_status[afc_pkg::AFC_ST_RDY] = !busy;
        command_status[afc_pkg::AFC_ST_DSC] = 1'b1;
        command_status[afc_pkg::AFC_ST_DRQ] =
            (state == afc_pkg::AFC_TABLE);
        command_status[afc_pkg::AFC_ST_ERR] = abort_flag && !busy;
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_finish;
        state == afc_pkg::AFC_DONE ##1 state == afc_pkg::AFC_IDLE;
    endsequence
    sequence s_abort_end;
        state == afc_pkg::AFC_DONE && abort_flag
        ##1 command_status[afc_pkg::AFC_ST_ERR] && !busy;
    endsequence
    AST_TRACK_RANGE_ABORT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cmd_fire && dat_i[7:0] == afc_pkg::AFC_OP_TRACK && !in_range
        |=> s_abort_end)
        else $error("out of range track format not aborted");
    AST_UNIT_NEEDS_PREPARE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cmd_fire && dat_i[7:0] == afc_pkg::AFC_OP_UNIT && !prepared
        |=> s_abort_end)
        else $error("unprepared unit format not aborted");
    AST_UNIT_NO_DRQ: assert property (
        @(posedge clk_i) disable iff (rst_i)
        busy && unit_mode |-> !command_status[afc_pkg::AFC_ST_DRQ])
        else $error("drq raised during unit format");
    AST_WRITE_IN_WINDOW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        zero_wr_req_o |-> zero_wr_lba_o <= last_lba && !defect_hit_i)
        else $error("zero write outside the formatted span");
    AST_MERGE_BEFORE_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(state == afc_pkg::AFC_ISSUE) && unit_mode
        |-> $past(merge_ack_i) && cur_lba == 28'h0)
        else $error("unit format wrote before merging defects");
    AST_COMMIT_AT_END: assert property (
        @(posedge clk_i) disable iff (rst_i)
        records_commit_o |-> $past(state == afc_pkg::AFC_DONE)
                             && !busy && unit_mode)
        else $error("records committed outside completion");
    AST_COMPLETION_STATUS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state == afc_pkg::AFC_DONE |-> s_finish
        ##0 command_status[afc_pkg::AFC_ST_RDY]
        && command_status[afc_pkg::AFC_ST_ERR] == abort_flag)
        else $error("completion status wrong");
    AST_LBA_REPORT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state == afc_pkg::AFC_DONE && !unit_mode && lba_mode && !abort_flag
        |=> sector_number == $past(cur_lba[7:0])
            && cylinder_high == $past(cur_lba[23:16]))
        else $error("current lba not reported");
    AST_TABLE_LENGTH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        data_fire && table_count == afc_pkg::AFC_TABLE_WORDS_M1
        |=> state == afc_pkg::AFC_ISSUE && cur_lba == $past(first_lba))
        else $error("track start not taken after format table");

endmodule

`default_nettype wire

// ==== rtl/afc_pkg.sv ====
package afc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] AFC_OFS_DATA      = 8'h00;
    localparam logic [7:0] AFC_OFS_FEATURE   = 8'h04;
    localparam logic [7:0] AFC_OFS_SECT_CNT  = 8'h08;
    localparam logic [7:0] AFC_OFS_SECT_NUM  = 8'h0c;
    localparam logic [7:0] AFC_OFS_CYL_LOW   = 8'h10;
    localparam logic [7:0] AFC_OFS_CYL_HIGH  = 8'h14;
    localparam logic [7:0] AFC_OFS_DEV_HEAD  = 8'h18;
    localparam logic [7:0] AFC_OFS_COMMAND   = 8'h1c;
    localparam logic [7:0] AFC_OFS_NATIVE    = 8'h20;

    // ****************************************
    // opcodes and feature value
    // ****************************************
    localparam logic [7:0] AFC_OP_TRACK      = 8'h50;
    localparam logic [7:0] AFC_OP_UNIT       = 8'hf7;
    localparam logic [7:0] AFC_FEATURE_UNIT  = 8'h11;

    // ****************************************
    // field positions
    // ****************************************
    localparam int AFC_DH_LBA_BIT    = 6;
    localparam int AFC_ST_BSY        = 7;
    localparam int AFC_ST_RDY        = 6;
    localparam int AFC_ST_DSC        = 4;
    localparam int AFC_ST_DRQ        = 3;
    localparam int AFC_ST_ERR        = 0;
    localparam int AFC_ER_IDN        = 4;
    localparam int AFC_ER_ABT        = 2;

    // ****************************************
    // reset values and geometry
    // ****************************************
    localparam logic [7:0]  AFC_RST_DEV_HEAD  = 8'ha0;
    localparam logic [27:0] AFC_RST_NATIVE    = 28'hfffffff;
    localparam int unsigned AFC_SECTORS_PER_TRACK = 63;
    localparam int unsigned AFC_HEADS         = 16;
    localparam logic [7:0]  AFC_TABLE_WORDS_M1 = 8'hff;

    typedef enum logic [2:0] {
        AFC_IDLE  = 3'b000,
        AFC_TABLE = 3'b001,
        AFC_MERGE = 3'b010,
        AFC_ISSUE = 3'b011,
        AFC_DONE  = 3'b100
    } afc_state_t;

endpackage

// ==== rtl/afc_track_calc.sv ====
`timescale 1ns/10ps
`default_nettype none

module afc_track_calc (
    // addressing inputs
    input  wire logic        lba_mode_i,
    input  wire logic [7:0]  sector_number_i,
    input  wire logic [15:0] cylinder_i,
    input  wire logic [3:0]  head_i,
    input  wire logic [27:0] native_top_i,
    // track window
    output logic      [27:0] target_lba_o,
    output logic      [27:0] first_lba_o,
    output logic      [27:0] last_lba_o,
    output logic             in_range_o
);

    logic [31:0] target;
    logic [31:0] first;
    logic [31:0] last;

    always_comb begin
        if (lba_mode_i) begin
            target = {4'h0, head_i, cylinder_i, sector_number_i};
            // whole logical track that holds the lba
            first  = target - (target % afc_pkg::AFC_SECTORS_PER_TRACK);
        end else begin
            target = (32'(cylinder_i) * afc_pkg::AFC_HEADS + 32'(head_i))
                     * afc_pkg::AFC_SECTORS_PER_TRACK;
            first  = target;
        end
        last = first + afc_pkg::AFC_SECTORS_PER_TRACK - 32'd1;
        if (last > 32'(native_top_i)) begin
            last = 32'(native_top_i);
        end
    end

    assign target_lba_o = target[27:0];
    assign first_lba_o  = first[27:0];
    assign last_lba_o   = last[27:0];
    assign in_range_o   = (target <= 32'(native_top_i));

endmodule

`default_nettype wire

// ==== tb/afc_media_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// acks zero writes after lag_i cycles, flags one bad sector
module afc_media_model (
    // clock and scenario clear
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    // zero-write port
    input  wire logic        req_i,
    input  wire logic [27:0] lba_i,
    input  wire logic [27:0] bad_lba_i,
    input  wire logic [1:0]  lag_i,
    output logic             ack_o,
    output logic             bad_o,
    // defect records
    input  wire logic        merge_req_i,
    output logic             merge_ack_o,
    // observations
    output logic      [31:0] cnt_o,
    output logic      [27:0] first_o,
    output logic      [27:0] last_o,
    output logic             oops_o
);
    logic [1:0] wait_q;
    logic       hit;

    assign bad_o = (lba_i == bad_lba_i);
    assign hit = (wait_q == lag_i);

    always_ff @(posedge clk_i) begin
        ack_o       <= req_i && !ack_o && !clr_i && hit;
        merge_ack_o <= merge_req_i && !merge_ack_o;
        wait_q      <= (clr_i || !req_i || hit) ? 2'h0 : wait_q + 2'h1;
        if (clr_i) begin
            cnt_o  <= 32'h0;
            oops_o <= 1'b0;
        end else if (req_i && ack_o) begin
            cnt_o   <= cnt_o + 32'h1;
            last_o  <= lba_i;
            first_o <= (cnt_o == 32'h0) ? lba_i : first_o;
            oops_o  <= oops_o | (cnt_o != 32'h0 && lba_i <= last_o);
        end else if (merge_req_i) begin
            // a merge after any sector write is out of order
            oops_o <= oops_o | (cnt_o != 32'h0);
        end
    end
endmodule
`default_nettype wire

// ==== tb/ata_format_command_handler_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module ata_format_command_handler_bench;
    localparam logic [7:0] CMD = afc_pkg::AFC_OFS_COMMAND;
    localparam logic [7:0] NAT = afc_pkg::AFC_OFS_NATIVE;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, prep, clr;
    logic        zreq, zack, bad, mreq, mack, commit, oops;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd, cnt;
    logic [27:0] zlba, bad_lba, first_lba, last_lba;
    logic [1:0]  lag;
    int          fails, checked, commits;

    afc_format_ctrl uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .zero_wr_req_o(zreq),
        .zero_wr_lba_o(zlba), .zero_wr_ack_i(zack), .defect_hit_i(bad),
        .merge_req_o(mreq), .merge_ack_i(mack),
        .records_commit_o(commit), .erase_prepared_i(prep));
    afc_media_model media (
        .clk_i(clk_i), .clr_i(clr), .req_i(zreq), .lba_i(zlba),
        .bad_lba_i(bad_lba), .lag_i(lag), .ack_o(zack), .bad_o(bad),
        .merge_req_i(mreq), .merge_ack_o(mack), .cnt_o(cnt),
        .first_o(first_lba), .last_o(last_lba), .oops_o(oops));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (commit === 1'b1) commits++;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one classic wishbone cycle, read data left in rd
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (ack_o !== 1'b1) begin
            check("ack", 32'h0, 32'h1);
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask

    // poll until not busy, then compare status and error
    task automatic ends(input logic [7:0] st, er);
        int n;
        n = 0;
        do begin
            wb(1'b0, CMD, 32'h0);
            n++;
        end while (rd[7] !== 1'b0 && n < 3000); // generous bound
        check("status", rd, {24'h0, st});
        if (rd[7] !== 1'b0) tally_and_finish();
        wb(1'b0, afc_pkg::AFC_OFS_FEATURE, 32'h0);
        check("error", rd, {24'h0, er});
    endtask

    // v holds device/head, cyl high, cyl low, sector number
    task automatic track(input logic [31:0] v, input bit tbl);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        for (int i = 0; i < 4; i++)
            wb(1'b1, afc_pkg::AFC_OFS_SECT_NUM + 8'(4 * i),
               {24'h0, v[8*i +: 8]});
        wb(1'b1, CMD, {24'h0, afc_pkg::AFC_OP_TRACK});
        if (tbl) begin
            wb(1'b0, CMD, 32'h0);
            check("drq", rd & 32'h8, 32'h8);
            for (int i = 0; i < 256; i++)
                wb(1'b1, afc_pkg::AFC_OFS_DATA, 32'(i));
        end
    endtask

    task automatic t_reset();
        wb(1'b0, afc_pkg::AFC_OFS_DEV_HEAD, 32'h0);
        check("dev_head", rd, 32'ha0);
        wb(1'b0, NAT, 32'h0);
        check("native", rd, 32'hfffffff);
        wb(1'b0, 8'h24, 32'h0);
        check("unmapped", rd, 32'h0);
        ends(8'h50, 8'h00);
    endtask

    task automatic t_lba();
        logic [31:0] f, m;
        f = (32'h1000050 / 32'h3f) * 32'h3f;
        wb(1'b1, NAT, 32'h1000100);
        bad_lba <= f[27:0] + 28'h5;
        lag <= 2'h2;
        track({8'he1, 24'h000050}, 1'b1);
        ends(8'h50, 8'h00);
        check("writes", cnt, 32'h3e);
        check("first", {4'h0, first_lba}, f);
        check("last", {4'h0, last_lba}, f + 32'h3e);
        check("order", {31'h0, oops}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 32'hf : 32'hff;
            wb(1'b0, afc_pkg::AFC_OFS_SECT_NUM + 8'(4 * i), 32'h0);
            check("lba_back", rd & m, ((f + 32'h3e) >> (8 * i)) & m);
        end
    endtask

    task automatic t_chs_range();
        logic [31:0] f;
        f = (32'h4104 * 32'h10 + 32'h5) * 32'h3f;
        lag <= 2'h0;
        track({8'ha5, 24'h410400}, 1'b1);
        ends(8'h50, 8'h00);
        check("writes", cnt, 32'h1000101 - f);
        check("first", {4'h0, first_lba}, f);
        check("last", {4'h0, last_lba}, 32'h1000100);
        track({8'he1, 24'h000101}, 1'b0);
        ends(8'h51, 8'h04);
        check("writes", cnt, 32'h0);
    endtask

    task automatic t_unit();
        int c;
        wb(1'b1, NAT, 32'hff);
        wb(1'b1, afc_pkg::AFC_OFS_FEATURE, 32'h11);
        wb(1'b1, CMD, {24'h0, afc_pkg::AFC_OP_UNIT});
        ends(8'h51, 8'h04);
        check("writes", cnt, 32'h0);
        prep <= 1'b1;
        @(posedge clk_i);
        prep <= 1'b0;
        c = commits;
        wb(1'b1, CMD, {24'h0, afc_pkg::AFC_OP_UNIT});
        wb(1'b0, CMD, 32'h0);
        check("busy", rd & 32'h88, 32'h80);
        wb(1'b1, NAT, 32'h7);
        ends(8'h50, 8'h00);
        check("writes", cnt, 32'h100);
        check("first", {4'h0, first_lba}, 32'h0);
        check("last", {4'h0, last_lba}, 32'hff);
        check("merge", {31'h0, oops}, 32'h0);
        check("commit", 32'(commits - c), 32'h1);
        wb(1'b0, NAT, 32'h0);
        check("native", rd, 32'hff);
    endtask

    task automatic t_other();
        wb(1'b1, CMD, 32'h90);
        ends(8'h51, 8'h04);
    endtask

    initial begin
        {rst_i, clr, prep, cyc_i, stb_i, we_i} = 6'b110000;
        {adr_i, dat_i, lag, bad_lba} = '0;
        fails = 0;
        checked = 0;
        commits = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        $display("reset test done");
        t_lba();
        $display("lba track test done");
        t_chs_range();
        $display("chs and range test done");
        t_unit();
        $display("unit format test done");
        t_other();
        $display("other opcode test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
